// ---- core/ccpu_unit.sv ----
// Capture/compare/PWM unit with APB register access
// Functional notes
// - Mode field selects off, four capture, four compare and PWM modes.
// - Capture copies timer1 into value pair, sets flag; overwrite allowed.
// - Prescaler counter cleared when off, outside capture, and on reset.
// - Switching between capture prescalers keeps the counter running.
// - Compare value with timer1 every cycle; act on pin, set flag.
// - Writing zero to control forces the unit output latch low.
// - Flag-only compare sets flag without touching the pin.
// - First unit's trigger resets timer1 on compare match.
// - Second unit's trigger also starts conversion when converter enabled.
// - Trigger reset of timer1 never sets timer1 overflow flag.
// - PWM period is period register plus one times timer2 steps.
// - After period match: clear timer2, set pin unless zero duty, reload.
// - Timer2 postscaler plays no part in the PWM period.
// - Duty is value low byte above control bits 5:4.
// - Duty writes take effect at period match; high byte read-only.
// - Active duty against timer2 plus two low bits clears the pin.
// - Duty beyond the period leaves the pin high all period.
//
// Our own choices: the APB interface to the registers and the register addresses.
`include "ccpu_regs.svh"

module ccpu_unit #(
    parameter bit IS_SECOND_UNIT = 1'b0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire ccpu_pkg::ccpu_addr_t paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [15:0]       capture_timebase_count,
    input  wire logic [7:0]        pwm_timebase_count,
    input  wire logic [1:0]        pwm_phase_bits,
    input  wire logic              pwm_step,
    input  wire logic [7:0]        pwm_period_register,
    input  wire logic              adc_enabled,
    input  wire logic              unit_io_pin_in,
    output logic                   unit_io_pin_out,
    output logic                   timer1_reset,
    output logic                   timer1_ovf_inhibit,
    output logic                   pwm_timer_clear,
    output logic                   adc_start,
    output logic                   unit_irq
);
    import ccpu_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0]  mode_ff,    nxt_mode;
    logic [1:0]  dlb_ff,     nxt_dlb;
    logic [15:0] value_ff,   nxt_value;
    logic [1:0]  act_lsb_ff, nxt_act_lsb;
    logic [3:0]  presc_ff,   nxt_presc;
    logic        flag_ff,    nxt_flag;
    logic        ena_ff,     nxt_ena;
    logic        pin_ff,     nxt_pin;
    logic        hit_ff,     nxt_hit;
    logic        pin_d_ff;
    logic        rst_ff,     nxt_rst;
    logic        adc_ff,     nxt_adc;
    logic        clr_ff,     nxt_clr;
    logic        irq_ff;
    logic [31:0] rdata_ff,   nxt_rdata;
    logic        rdy_ff,     nxt_rdy;
    logic        err_ff,     nxt_err;
    logic        pin_sync;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        is_cap, is_cmp, is_pwm;
    logic        rise, fall, cap_evt, eq, cmp_hit, period_hit, duty_hit;
    logic        wr_acc, setup;
    logic [9:0]  duty_new;

    ccpu_sync2 u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (unit_io_pin_in),
        .sync_out (pin_sync)
    );

    always_comb begin
        is_cap = (mode_ff[3:2] == 2'b01);
        is_cmp = (mode_ff[3:2] == 2'b10);
        is_pwm = (mode_ff[3:2] == 2'b11);
        rise = pin_sync & ~pin_d_ff;
        fall = ~pin_sync & pin_d_ff;
        case (mode_ff)
            CCPU_CAP_FALL:  cap_evt = fall;
            CCPU_CAP_RISE:  cap_evt = rise;
            CCPU_CAP_DIV4:  cap_evt = rise
                                && presc_ff[1:0] == 2'(`CCPU_PRESC_DIV4);
            CCPU_CAP_DIV16: cap_evt = rise
                                && presc_ff == `CCPU_PRESC_DIV16;
            default:        cap_evt = 1'b0;
        endcase
        eq = (capture_timebase_count == value_ff);
        cmp_hit = is_cmp && eq && !hit_ff;
        // Postscaler not involved in the period
        period_hit = is_pwm && pwm_step
                     && pwm_timebase_count == pwm_period_register;
        // One cycle ahead, the pin latch adds a cycle
        // Longer duty than period never matches
        duty_hit = is_pwm && {value_ff[15:8], act_lsb_ff}
                   == 10'({pwm_timebase_count, pwm_phase_bits} + 10'h001);
        duty_new = {value_ff[7:0], dlb_ff};
        setup  = psel && !penable;
        wr_acc = psel && penable && rdy_ff && pwrite;
    end

    // ------------------------------------------------------------
    // Unit logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_mode    = mode_ff;
        nxt_dlb     = dlb_ff;
        nxt_value   = value_ff;
        nxt_act_lsb = act_lsb_ff;
        nxt_presc   = presc_ff;
        nxt_flag    = flag_ff;
        nxt_ena     = ena_ff;
        nxt_pin     = pin_ff;
        nxt_hit     = is_cmp && eq;
        nxt_rst     = 1'b0;
        nxt_adc     = 1'b0;
        nxt_clr     = 1'b0;
        // Software accesses first, hardware events override
        if (wr_acc) begin
            if (paddr == `CCPU_OFS_CONTROL) begin
                nxt_mode = pwdata[`CCPU_CTL_MODE_LSB +: 4];
                nxt_dlb  = pwdata[`CCPU_CTL_DUTY_LSB +: 2];
            end else if (paddr == `CCPU_OFS_VALUE_LO) begin
                nxt_value[7:0] = pwdata[7:0];
            end else if (paddr == `CCPU_OFS_VALUE_HI) begin
                if (!is_pwm) begin
                    nxt_value[15:8] = pwdata[7:0];
                end
            end else if (paddr == `CCPU_OFS_STATUS) begin
                if (pwdata[`CCPU_STS_FLAG_BIT]) begin
                    nxt_flag = 1'b0;
                end
            end else if (paddr == `CCPU_OFS_ENABLE) begin
                nxt_ena = pwdata[`CCPU_ENA_BIT];
            end
        end
        // Prescaler counts rising edges in any capture mode
        if (!is_cap) begin
            nxt_presc = `CCPU_RST_PRESC;
        end else if (rise) begin
            nxt_presc = presc_ff + 4'h1;
        end
        if (cap_evt) begin
            nxt_value = capture_timebase_count;
            nxt_flag  = 1'b1;
        end
        if (cmp_hit) begin
            nxt_flag = 1'b1;
            case (mode_ff)
                CCPU_CMP_SET: nxt_pin = 1'b1;
                CCPU_CMP_CLR: nxt_pin = 1'b0;
                CCPU_CMP_TRIG: begin
                    nxt_rst = 1'b1;
                    nxt_adc = IS_SECOND_UNIT && adc_enabled;
                end
                default: nxt_pin = pin_ff;
            endcase
        end
        if (duty_hit) begin
            nxt_pin = 1'b0;
        end
        if (period_hit) begin
            nxt_clr         = 1'b1;
            nxt_pin         = (duty_new != 10'h000);
            nxt_value[15:8] = value_ff[7:0];
            nxt_act_lsb     = dlb_ff;
        end
        if (mode_ff == CCPU_OFF) begin
            nxt_pin = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err   = 1'b0;
        nxt_rdy   = setup;
        if (setup) begin
            nxt_rdata = 32'h0000_0000;
            if (paddr == `CCPU_OFS_CONTROL) begin
                nxt_rdata[5:0] = {dlb_ff, mode_ff};
            end else if (paddr == `CCPU_OFS_VALUE_LO) begin
                nxt_rdata[7:0] = value_ff[7:0];
            end else if (paddr == `CCPU_OFS_VALUE_HI) begin
                nxt_rdata[7:0] = value_ff[15:8];
            end else if (paddr == `CCPU_OFS_STATUS) begin
                nxt_rdata[`CCPU_STS_FLAG_BIT] = flag_ff;
            end else if (paddr == `CCPU_OFS_ENABLE) begin
                nxt_rdata[`CCPU_ENA_BIT] = ena_ff;
            end else begin
                nxt_err = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff    <= `CCPU_RST_MODE;
            dlb_ff     <= `CCPU_RST_DUTY_LSB;
            value_ff   <= `CCPU_RST_VALUE;
            act_lsb_ff <= `CCPU_RST_DUTY_LSB;
            presc_ff   <= `CCPU_RST_PRESC;
            flag_ff    <= 1'b0;
            ena_ff     <= 1'b0;
            pin_ff     <= 1'b0;
            hit_ff     <= 1'b0;
            pin_d_ff   <= 1'b0;
            rst_ff     <= 1'b0;
            adc_ff     <= 1'b0;
            clr_ff     <= 1'b0;
            irq_ff     <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rdy_ff     <= 1'b0;
            err_ff     <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            dlb_ff     <= nxt_dlb;
            value_ff   <= nxt_value;
            act_lsb_ff <= nxt_act_lsb;
            presc_ff   <= nxt_presc;
            flag_ff    <= nxt_flag;
            ena_ff     <= nxt_ena;
            pin_ff     <= nxt_pin;
            hit_ff     <= nxt_hit;
            pin_d_ff   <= pin_sync;
            rst_ff     <= nxt_rst;
            adc_ff     <= nxt_adc;
            clr_ff     <= nxt_clr;
            irq_ff     <= flag_ff & ena_ff;
            rdata_ff   <= nxt_rdata;
            rdy_ff     <= nxt_rdy;
            err_ff     <= nxt_err;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata             = rdata_ff;
    assign pready             = rdy_ff;
    assign pslverr            = err_ff;
    assign unit_io_pin_out    = pin_ff;
    assign timer1_reset       = rst_ff;
    assign timer1_ovf_inhibit = rst_ff;
    assign pwm_timer_clear    = clr_ff;
    assign adc_start          = adc_ff;
    assign unit_irq           = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_off_latch_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mode_ff == CCPU_OFF) |=> !unit_io_pin_out)
        else $error("output latch not low while unit off");

    chk_presc_cleared: assert property (
        @(posedge pclk) disable iff (!presetn)
        !is_cap |=> presc_ff == 4'h0)
        else $error("prescaler counter not cleared outside capture");

    chk_capture_copy: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_evt |=> value_ff == $past(capture_timebase_count) && flag_ff)
        else $error("capture did not copy timer1 or set flag");

    chk_cmp_set_pin: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cmp_hit && mode_ff == CCPU_CMP_SET) |=> unit_io_pin_out && flag_ff)
        else $error("set-on-match did not raise pin and flag");

    chk_cmp_clr_pin: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cmp_hit && mode_ff == CCPU_CMP_CLR) |=> !unit_io_pin_out)
        else $error("clear-on-match did not lower pin");

    chk_flag_only_pin: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cmp_hit && mode_ff == CCPU_CMP_FLAG)
        |=> $stable(unit_io_pin_out) && flag_ff)
        else $error("flag-only compare touched pin");

    chk_trig_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cmp_hit && mode_ff == CCPU_CMP_TRIG)
        |=> timer1_reset ##1 !timer1_reset)
        else $error("trigger did not pulse timer1 reset");

    chk_adc_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        adc_start |-> timer1_reset && IS_SECOND_UNIT && $past(adc_enabled))
        else $error("conversion start without enabled converter");

    chk_irq_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flag_ff && ena_ff) |=> unit_irq)
        else $error("interrupt request missing");

    chk_pwm_reload: assert property (
        @(posedge pclk) disable iff (!presetn)
        period_hit |=> pwm_timer_clear
        && value_ff[15:8] == $past(value_ff[7:0])
        && unit_io_pin_out == ($past(duty_new) != 10'h000))
        else $error("period match did not reload duty and pin");

    chk_pwm_pin_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (duty_hit && !period_hit) |=> !unit_io_pin_out)
        else $error("duty match did not clear pin");
endmodule

// ---- core/ccpu_regs.svh ----
// Register offsets, field positions, reset values and codes of the unit
`ifndef CCPU_REGS_SVH
`define CCPU_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCPU_OFS_CONTROL   8'h00
`define CCPU_OFS_VALUE_LO  8'h04
`define CCPU_OFS_VALUE_HI  8'h08
`define CCPU_OFS_STATUS    8'h0c
`define CCPU_OFS_ENABLE    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCPU_CTL_MODE_LSB  0
`define CCPU_CTL_DUTY_LSB  4
`define CCPU_STS_FLAG_BIT  0
`define CCPU_ENA_BIT       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCPU_RST_MODE      4'h0
`define CCPU_RST_DUTY_LSB  2'h0
`define CCPU_RST_VALUE     16'h0000
`define CCPU_RST_PRESC     4'h0

// ----------------------------------------------------------------
// Capture prescaler terminal counts
// ----------------------------------------------------------------
`define CCPU_PRESC_DIV4    4'h3
`define CCPU_PRESC_DIV16   4'hf

`endif

// ---- core/ccpu_pkg.sv ----
// Types shared by the capture/compare/PWM unit
package ccpu_pkg;

    // ------------------------------------------------------------
    // Mode field encodings
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CCPU_OFF       = 4'h0,
        CCPU_CAP_FALL  = 4'h4,
        CCPU_CAP_RISE  = 4'h5,
        CCPU_CAP_DIV4  = 4'h6,
        CCPU_CAP_DIV16 = 4'h7,
        CCPU_CMP_SET   = 4'h8,
        CCPU_CMP_CLR   = 4'h9,
        CCPU_CMP_FLAG  = 4'ha,
        CCPU_CMP_TRIG  = 4'hb
    } ccpu_mode_t;

    typedef logic [7:0] ccpu_addr_t;

endpackage

// ---- core/ccpu_sync2.sv ----
// Two-flop synchroniser for one pin level
module ccpu_sync2 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff  <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ---- test/ccpu_timers.sv ----
// Behavioural timer1 and timer2 model facing the unit
module ccpu_timers (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        t1_run,
    input  wire logic        t1_load,
    input  wire logic [15:0] t1_seed,
    input  wire logic [7:0]  t2_period,
    input  wire logic        timer1_reset,
    input  wire logic        pwm_timer_clear,
    output logic      [15:0] t1_count,
    output logic      [7:0]  t2_count,
    output logic      [1:0]  t2_phase,
    output logic             t2_step
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Timers, prescale 1, postscaler absent
    // ------------------------------------------------------------
    assign t2_step = (t2_phase == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_count <= 16'h0000;
            t2_count <= 8'h00;
            t2_phase <= 2'h0;
        end else begin
            t2_phase <= t2_phase + 2'h1;
            if (timer1_reset) begin
                t1_count <= 16'h0000;
            end else if (t1_load) begin
                t1_count <= t1_seed;
            end else if (t1_run) begin
                t1_count <= t1_count + 16'h0001;
            end
            if (pwm_timer_clear) begin
                t2_count <= 8'h00;
            end else if (t2_step) begin
                t2_count <= (t2_count == t2_period) ? 8'h00
                                                    : t2_count + 8'h01;
            end
        end
    end
endmodule

// ---- test/tb.sv ----
// Self-checking bench of the capture/compare/PWM unit
`include "ccpu_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ccpu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    ccpu_addr_t paddr;
    logic [31:0] pwdata, prdata, v;
    logic [15:0] t1c, t1_seed;
    logic [7:0]  t2c, pr;
    logic [1:0]  ph;
    logic stp, pin_in, pin_out, t1_rst, inh, t2_clr, adc_st, irq;
    logic t1_run, t1_load, er;
    logic adc_en, port_dir_out;
    int trig_cnt, inh_cnt, adc_cnt;
    int failures, tests_run, cyc, seed, d, n;

    ccpu_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_timebase_count(t1c),
        .pwm_timebase_count(t2c), .pwm_phase_bits(ph), .pwm_step(stp),
        .pwm_period_register(pr), .adc_enabled(adc_en),
        .unit_io_pin_in(pin_in), .unit_io_pin_out(pin_out),
        .timer1_reset(t1_rst), .timer1_ovf_inhibit(inh),
        .pwm_timer_clear(t2_clr), .adc_start(adc_st), .unit_irq(irq));
    ccpu_timers i_tmr (.pclk(pclk), .presetn(presetn), .t1_run(t1_run),
        .t1_load(t1_load), .t1_seed(t1_seed), .t2_period(pr),
        .timer1_reset(t1_rst), .pwm_timer_clear(t2_clr),
        .t1_count(t1c), .t2_count(t2c), .t2_phase(ph), .t2_step(stp));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input ccpu_addr_t a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse_pin(input int cnt);
        repeat (cnt) begin
            @(posedge pclk) pin_in <= 1'b1;
            repeat (6) @(posedge pclk);
            pin_in <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask
    task automatic cmp_run(input logic [3:0] m, input logic p);
        logic [15:0] tgt;
        apb(1, `CCPU_OFS_STATUS, 1);
        tgt = t1c + 16'd40;
        apb(1, `CCPU_OFS_VALUE_LO, {24'h0, tgt[7:0]});
        apb(1, `CCPU_OFS_VALUE_HI, {24'h0, tgt[15:8]});
        apb(1, `CCPU_OFS_CONTROL, {28'h0, m});
        repeat (60) @(posedge pclk);
        chk(pin_out, p);
        apb(0, `CCPU_OFS_STATUS, 0);
        chk(v[0], 1);
    endtask
    function automatic int exp_high(input int dt, input int per);
        if (dt == 0) return 0;
        if (dt >= per) return per;
        return dt;
    endfunction

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        trig_cnt += (t1_rst === 1'b1);
        inh_cnt += (t1_rst === 1'b1 && inh === 1'b1);
        adc_cnt += (adc_st === 1'b1);
        if (cyc == 30000) begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'he501;
        {psel, penable, pwrite, pin_in, t1_run, t1_load} = 6'h0;
        adc_en = 1'b0;
        port_dir_out = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        t1_seed = 16'h0;
        pr = 8'd9;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CCPU_OFS_CONTROL, 0);
        chk(v, 0);
        apb(0, 8'h20, 0);
        chk(v, 0);
        chk(er, 1);
        $display("test reset done");
        for (int m = 4; m < 6; m++) begin
            apb(1, `CCPU_OFS_CONTROL, 0);
            pin_in <= (m == 4);
            t1_seed <= 16'($random(seed));
            t1_load <= 1'b1;
            @(posedge pclk) t1_load <= 1'b0;
            apb(1, `CCPU_OFS_STATUS, 1);
            apb(1, `CCPU_OFS_CONTROL, m);
            @(posedge pclk) pin_in <= (m != 4);
            repeat (8) @(posedge pclk);
            apb(0, `CCPU_OFS_VALUE_LO, 0);
            chk(v, {24'h0, t1_seed[7:0]});
            apb(0, `CCPU_OFS_VALUE_HI, 0);
            chk(v, {24'h0, t1_seed[15:8]});
            apb(0, `CCPU_OFS_STATUS, 0);
            chk(v[0], 1);
            apb(1, `CCPU_OFS_STATUS, 1);
            apb(0, `CCPU_OFS_STATUS, 0);
            chk(v[0], 0);
        end
        for (int m = 6; m < 8; m++) begin
            n = (m == 6) ? 4 : 16;
            pin_in <= 1'b0;
            apb(1, `CCPU_OFS_CONTROL, 0);
            apb(1, `CCPU_OFS_STATUS, 1);
            apb(1, `CCPU_OFS_CONTROL, m);
            pulse_pin(n - 1);
            apb(0, `CCPU_OFS_STATUS, 0);
            chk(v[0], 0);
            pulse_pin(1);
            apb(0, `CCPU_OFS_STATUS, 0);
            chk(v[0], 1);
        end
        $display("test capture done");
        t1_run <= 1'b1;
        port_dir_out <= 1'b1;
        apb(1, `CCPU_OFS_CONTROL, 0);
        apb(1, `CCPU_OFS_STATUS, 1);
        apb(1, `CCPU_OFS_ENABLE, 1);
        cmp_run(4'h8, 1'b1);
        chk(irq, 1);
        apb(1, `CCPU_OFS_STATUS, 1);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        cmp_run(4'h9, 1'b0);
        cmp_run(4'h8, 1'b1);
        cmp_run(4'ha, 1'b1);
        adc_en <= 1'b1;
        cmp_run(4'hb, 1'b1);
        chk(t1c < 16'd40, 1);
        chk(trig_cnt != 0, 1);
        chk(inh_cnt, trig_cnt);
        chk(adc_cnt, 0);
        apb(1, `CCPU_OFS_CONTROL, 0);
        repeat (2) @(posedge pclk);
        chk(pin_out, 0);
        $display("test compare done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 0 : (i == 1) ? 1023 : 1 + ($random(seed) & 31);
            apb(1, `CCPU_OFS_VALUE_LO, d >> 2);
            apb(1, `CCPU_OFS_CONTROL, {26'h0, 2'(d), 4'hc});
            repeat (100) @(posedge pclk);
            n = 0;
            repeat (40) begin
                @(posedge pclk);
                n += (pin_out === 1'b1 && port_dir_out === 1'b1);
            end
            chk(n, exp_high(d, 40));
            apb(1, `CCPU_OFS_VALUE_HI, 32'hff);
            apb(0, `CCPU_OFS_VALUE_HI, 0);
            chk(v, d >> 2);
        end
        $display("test pwm done");
        give_verdict();
    end
endmodule
